// ### logic/exc_vec_pkg.sv
// constants and state types for the exception arbitration block
package exc_vec_pkg;

   // vector numbers, priority falls as the number rises
   localparam logic [5:0] VEC_RESET     = 6'h00;
   localparam logic [5:0] VEC_NMI       = 6'h03;
   localparam logic [5:0] VEC_BREAK     = 6'h05;
   localparam logic [5:0] VEC_EXT_FIRST = 6'h06;
   localparam logic [5:0] VEC_INT_FIRST = 6'h13;
   localparam logic [5:0] VEC_INT_LAST  = 6'h37;
   localparam int         NUM_VEC       = 56;
   localparam int         NUM_EXT       = 13;
   localparam int         NUM_INT       = 37;
   localparam int         VEC_ADDR_LSB  = 2;
   localparam int         VEC_ADDR_W    = 24;

   // sync bit positions: reset pin, nmi pin, then external pins in vector order
   localparam int         SYNC_RESET    = 0;
   localparam int         SYNC_NMI      = 1;
   localparam int         SYNC_EXT      = 2;
   localparam int         SYNC_W        = 15;

   // watchdog reset hold time
   localparam int         WDT_HOLD_NS   = 500;
   localparam int         CLOCK_NS      = 50;
   localparam int         WDT_HOLD_CYC  = (WDT_HOLD_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int         HOLD_CNT_W    = 4;

   // port registers
   localparam logic       PORT_SEL_DIR  = 1'b0;
   localparam logic       PORT_SEL_DATA = 1'b1;
   localparam logic [7:0] DIR_RESET     = 8'h00;
   localparam logic [7:0] DATA_RESET    = 8'h00;
   localparam logic [7:0] DIR_READ_VAL  = 8'hff;

   typedef enum logic [1:0] {
      ST_HOLD   = 2'b00,
      ST_VECTOR = 2'b01,
      ST_FIRST  = 2'b10,
      ST_RUN    = 2'b11
   } rst_state_t;

   typedef struct packed {
      rst_state_t              state;
      logic [HOLD_CNT_W-1:0]   hold_cnt;
      logic [SYNC_W-1:0]       sync1;
      logic [SYNC_W-1:0]       sync2;
      logic [SYNC_W-1:0]       prev;
      logic                    nmi_pend;
      logic [NUM_EXT-1:0]      ext_flag;
      logic                    i_mask;
      logic                    take;
      logic [5:0]              vec_num;
      logic [VEC_ADDR_W-1:0]   vec_addr;
      logic                    port_rst;
   } evp_state_t;

   typedef struct packed {
      logic [7:0]              dir;
      logic [7:0]              data;
      logic [7:0]              pin_s1;
      logic [7:0]              pin_s2;
      logic [7:0]              rdata;
   } port_state_t;

endpackage : exc_vec_pkg

// ### logic/port_ctrl_regs.sv
// port direction and output data registers with read and bit-clear paths
`timescale 1ns/1ns
module port_ctrl_regs (
   // clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // cpu access
   input  wire logic       port_sel,
   input  wire logic       port_wr,
   input  wire logic       port_rd,
   input  wire logic       port_bit_clear_instruction,
   input  wire logic [2:0] port_bit,
   input  wire logic [7:0] port_wdata,
   output logic      [7:0] port_rdata,
   // pins
   input  wire logic [7:0] port_pin_in,
   output logic      [7:0] port_output_data,
   output logic      [7:0] port_direction_control
);

   exc_vec_pkg::port_state_t s_r;
   exc_vec_pkg::port_state_t s_nxt;

   always_comb begin
      logic [7:0] rd_val;
      logic [7:0] mod_val;
      rd_val  = 8'h00;
      mod_val = 8'h00;
      s_nxt   = s_r;
      s_nxt.pin_s1 = port_pin_in;
      s_nxt.pin_s2 = s_r.pin_s1;
      if (port_sel == exc_vec_pkg::PORT_SEL_DIR) begin
         rd_val = exc_vec_pkg::DIR_READ_VAL;
      end else begin
         rd_val = (s_r.data & s_r.dir) | (s_r.pin_s2 & ~s_r.dir);
      end
      mod_val = rd_val & ~(8'h01 << port_bit);
      if (port_rd) begin
         s_nxt.rdata = rd_val;
      end
      if (port_wr || port_bit_clear_instruction) begin
         if (port_sel == exc_vec_pkg::PORT_SEL_DIR) begin
            s_nxt.dir = port_bit_clear_instruction ? mod_val : port_wdata;
         end else begin
            s_nxt.data = port_bit_clear_instruction ? mod_val : port_wdata;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '{dir: exc_vec_pkg::DIR_RESET, data: exc_vec_pkg::DATA_RESET,
                  pin_s1: 8'h00, pin_s2: 8'h00, rdata: 8'h00};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign port_rdata             = s_r.rdata;
   assign port_output_data       = s_r.data;
   assign port_direction_control = s_r.dir;

endmodule : port_ctrl_regs

// ### logic/exception_vector_priority.sv
// exception source arbitration, reset sequencing and vector selection
//
// Overview of operation
// - direction register reads back as all ones
// - bit clear reads byte, clears bit, writes byte
// - reset outranks all, vector zero
// - reset handling starts when reset pin releases
// - watchdog overflow resets chip like pin reset
// - mask bit blocks maskable external and internal requests
// - accept only at instruction or handling end
// - lowest pending vector number wins
// - vector address is four times vector number
// - vectors one, two, four never selected
// - internal requests use vectors nineteen to fifty-five
// - reset sets mask bit, then fetches reset vector
// - first instruction runs before any interrupt
// - nmi highest interrupt, ignores mask bit
`timescale 1ns/1ns
module exception_vector_priority #(
   parameter int WDT_HOLD = exc_vec_pkg::WDT_HOLD_CYC
) (
   // clock and reset
   input  wire logic                                   clock,
   input  wire logic                                   rst,
   // reset sources
   input  wire logic                                   external_reset_pin_n,
   input  wire logic                                   watchdog_overflow,
   // external request pins, active low, falling edge
   input  wire logic                                   nmi_pin_n,
   input  wire logic                                   pin_request_zero_n,
   input  wire logic                                   pin_request_one_n,
   input  wire logic                                   event_counter_request_n,
   input  wire logic                                   pin_request_three_n,
   input  wire logic                                   pin_request_four_n,
   input  wire logic [7:0]                             wakeup_request_n,
   input  wire logic [exc_vec_pkg::NUM_EXT-1:0]        ext_flag_clear,
   output logic      [exc_vec_pkg::NUM_EXT-1:0]        ext_flag,
   // internal requests, levels held by the source
   input  wire logic                                   address_break_req,
   input  wire logic [exc_vec_pkg::NUM_INT-1:0]        internal_req,
   // cpu sequencer
   input  wire logic                                   instr_boundary,
   input  wire logic                                   ccr_i_write,
   input  wire logic                                   ccr_i_wdata,
   output logic                                        ccr_i_mask,
   output logic                                        chip_reset,
   output logic                                        exc_take,
   output logic      [5:0]                             exc_vector_number,
   output logic      [exc_vec_pkg::VEC_ADDR_W-1:0]     exc_vector_address,
   // port registers
   input  wire logic                                   port_sel,
   input  wire logic                                   port_wr,
   input  wire logic                                   port_rd,
   input  wire logic                                   port_bit_clear_instruction,
   input  wire logic [2:0]                             port_bit,
   input  wire logic [7:0]                             port_wdata,
   output logic      [7:0]                             port_rdata,
   input  wire logic [7:0]                             port_pin_in,
   output logic      [7:0]                             port_output_data,
   output logic      [7:0]                             port_direction_control
);

   localparam logic [exc_vec_pkg::HOLD_CNT_W-1:0] HOLD_LOAD = exc_vec_pkg::HOLD_CNT_W'(WDT_HOLD - 1);

   exc_vec_pkg::evp_state_t s_r;
   exc_vec_pkg::evp_state_t s_nxt;

   logic [exc_vec_pkg::SYNC_W-1:0]  pins_raw;
   logic [exc_vec_pkg::SYNC_W-1:0]  fall;
   logic [exc_vec_pkg::NUM_VEC-1:0] pend;
   logic                            win_found;
   logic [5:0]                      win_vec;

   assign pins_raw = {wakeup_request_n, pin_request_four_n, pin_request_three_n,
                      event_counter_request_n, pin_request_one_n, pin_request_zero_n,
                      nmi_pin_n, external_reset_pin_n};

   // falling edges on the second sync stage only
   assign fall = s_r.prev & ~s_r.sync2;

   // pending set indexed by vector number
   always_comb begin
      pend = '0;
      pend[exc_vec_pkg::VEC_NMI] = s_r.nmi_pend;
      pend[exc_vec_pkg::VEC_BREAK] = address_break_req;
      for (int i = 0; i < exc_vec_pkg::NUM_EXT; i++) begin
         pend[int'(exc_vec_pkg::VEC_EXT_FIRST) + i] = s_r.ext_flag[i] & ~s_r.i_mask;
      end
      for (int i = 0; i < exc_vec_pkg::NUM_INT; i++) begin
         pend[int'(exc_vec_pkg::VEC_INT_FIRST) + i] = internal_req[i] & ~s_r.i_mask;
      end
      // reset is sequenced apart; 1, 2 and 4 have no source
      pend[0] = 1'b0;
      pend[1] = 1'b0;
      pend[2] = 1'b0;
      pend[4] = 1'b0;
   end

   // lowest number wins
   always_comb begin
      win_found = 1'b0;
      win_vec   = 6'h00;
      for (int v = exc_vec_pkg::NUM_VEC - 1; v >= 0; v--) begin
         if (pend[v]) begin
            win_found = 1'b1;
            win_vec   = 6'(v);
         end
      end
   end

   always_comb begin
      s_nxt       = s_r;
      s_nxt.sync1 = pins_raw;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.prev  = s_r.sync2;
      s_nxt.take  = 1'b0;

      // sticky flags, set wins over clear
      s_nxt.ext_flag = (s_r.ext_flag & ~ext_flag_clear)
                     | fall[exc_vec_pkg::SYNC_EXT +: exc_vec_pkg::NUM_EXT];
      if (fall[exc_vec_pkg::SYNC_NMI]) begin
         s_nxt.nmi_pend = 1'b1;
      end

      if (ccr_i_write) begin
         s_nxt.i_mask = ccr_i_wdata;
      end

      case (s_r.state)
         exc_vec_pkg::ST_HOLD: begin
            s_nxt.i_mask   = 1'b1;
            s_nxt.nmi_pend = 1'b0;
            s_nxt.ext_flag = '0;
            if (s_r.hold_cnt != '0) begin
               s_nxt.hold_cnt = s_r.hold_cnt - 1'b1;
            end else if (s_r.sync2[exc_vec_pkg::SYNC_RESET]) begin
               s_nxt.state = exc_vec_pkg::ST_VECTOR;
            end
         end
         exc_vec_pkg::ST_VECTOR: begin
            s_nxt.i_mask   = 1'b1;
            s_nxt.take     = 1'b1;
            s_nxt.vec_num  = exc_vec_pkg::VEC_RESET;
            s_nxt.vec_addr = '0;
            s_nxt.state    = exc_vec_pkg::ST_FIRST;
         end
         exc_vec_pkg::ST_FIRST: begin
            // boundary here ends reset handling; the first instruction follows unmolested
            if (instr_boundary) begin
               s_nxt.state = exc_vec_pkg::ST_RUN;
            end
         end
         exc_vec_pkg::ST_RUN: begin
            if (instr_boundary && win_found) begin
               s_nxt.take     = 1'b1;
               s_nxt.vec_num  = win_vec;
               s_nxt.vec_addr = exc_vec_pkg::VEC_ADDR_W'({win_vec, 2'b00});
               s_nxt.i_mask   = 1'b1;
               if (win_vec == exc_vec_pkg::VEC_NMI) begin
                  s_nxt.nmi_pend = fall[exc_vec_pkg::SYNC_NMI];
               end
            end
         end
         default: begin
            s_nxt.state = exc_vec_pkg::ST_HOLD;
         end
      endcase

      // reset sources outrank everything, pin first, then watchdog
      if (!s_r.sync2[exc_vec_pkg::SYNC_RESET]) begin
         s_nxt.state    = exc_vec_pkg::ST_HOLD;
         s_nxt.hold_cnt = '0;
         s_nxt.take     = 1'b0;
      end else if (watchdog_overflow) begin
         s_nxt.state    = exc_vec_pkg::ST_HOLD;
         s_nxt.hold_cnt = HOLD_LOAD;
         s_nxt.take     = 1'b0;
      end

      // registered copy of the hold state, glitch free for the port register reset
      s_nxt.port_rst = (s_nxt.state == exc_vec_pkg::ST_HOLD);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '{state: exc_vec_pkg::ST_HOLD, hold_cnt: '0, sync1: '0, sync2: '0,
                  prev: '1, nmi_pend: 1'b0, ext_flag: '0, i_mask: 1'b1, take: 1'b0,
                  vec_num: 6'h00, vec_addr: '0, port_rst: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign chip_reset         = (s_r.state == exc_vec_pkg::ST_HOLD);
   assign exc_take           = s_r.take;
   assign exc_vector_number  = s_r.vec_num;
   assign exc_vector_address = s_r.vec_addr;
   assign ccr_i_mask         = s_r.i_mask;
   assign ext_flag           = s_r.ext_flag;

   // port registers are reset with the chip, by the pin and the watchdog too
   port_ctrl_regs u_port (
      .clock                  (clock),
      .rst                    (rst | s_r.port_rst),
      .port_sel               (port_sel),
      .port_wr                (port_wr),
      .port_rd                (port_rd),
      .port_bit_clear_instruction              (port_bit_clear_instruction),
      .port_bit               (port_bit),
      .port_wdata             (port_wdata),
      .port_rdata             (port_rdata),
      .port_pin_in            (port_pin_in),
      .port_output_data       (port_output_data),
      .port_direction_control (port_direction_control)
   );

endmodule : exception_vector_priority

// ### testbench/exception_vector_priority_monitor.sv
// assertion checker for exception arbitration and port register outputs
`timescale 1ns/1ns
module exception_vector_priority_monitor (
   // clock and reset
   input wire logic                               clock,
   input wire logic                               rst,
   // reset and request sources
   input wire logic                               external_reset_pin_n,
   input wire logic                               watchdog_overflow,
   input wire logic                               address_break_req,
   // sequencer side
   input wire logic                               instr_boundary,
   input wire logic                               ccr_i_mask,
   input wire logic                               chip_reset,
   input wire logic                               exc_take,
   input wire logic [5:0]                         exc_vector_number,
   input wire logic [exc_vec_pkg::VEC_ADDR_W-1:0] exc_vector_address,
   // port registers
   input wire logic                               port_sel,
   input wire logic                               port_rd,
   input wire logic                               port_bit_clear_instruction,
   input wire logic [2:0]                         port_bit,
   input wire logic [7:0]                         port_rdata,
   input wire logic [7:0]                         port_direction_control
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   vec_addr_a: assert property (exc_take |-> exc_vector_address == {16'h0000, exc_vector_number, 2'b00})
      else $error("vector address mismatch");
   reserved_vec_a: assert property (exc_take |-> !(exc_vector_number inside {6'h01, 6'h02, 6'h04}))
      else $error("reserved vector taken");
   take_boundary_a: assert property (exc_take && exc_vector_number != 6'h00 |-> $past(instr_boundary))
      else $error("take without boundary");
   mask_block_a: assert property (exc_take && $past(ccr_i_mask) |-> exc_vector_number <= 6'h05)
      else $error("masked source taken");
   break_prio_a: assert property (exc_take && $past(address_break_req) |-> exc_vector_number <= 6'h05)
      else $error("break outranked");
   pin_reset_a: assert property ($fell(external_reset_pin_n) |-> ##[1:4] chip_reset)
      else $error("pin reset not seen");
   wdog_reset_a: assert property (watchdog_overflow |=> chip_reset)
      else $error("watchdog reset not seen");
   reset_vec_a: assert property ($fell(chip_reset) |-> ##[0:2] (exc_take && exc_vector_number == 6'h00))
      else $error("no reset vector after reset");
   dir_read_a: assert property (port_rd && !port_sel |=> port_rdata == 8'hff)
      else $error("direction read not all ones");
   dir_bit_clear_instruction_a: assert property (port_bit_clear_instruction && !port_sel |=>
      port_direction_control == (8'hff & ~(8'h01 << $past(port_bit))))
      else $error("direction bit clear wrong");
endmodule : exception_vector_priority_monitor

bind exception_vector_priority exception_vector_priority_monitor i_monitor (
   .clock(clock), .rst(rst), .external_reset_pin_n(external_reset_pin_n), .watchdog_overflow(watchdog_overflow),
   .address_break_req(address_break_req), .instr_boundary(instr_boundary), .ccr_i_mask(ccr_i_mask),
   .chip_reset(chip_reset), .exc_take(exc_take), .exc_vector_number(exc_vector_number),
   .exc_vector_address(exc_vector_address), .port_sel(port_sel), .port_rd(port_rd), .port_bit_clear_instruction(port_bit_clear_instruction),
   .port_bit(port_bit), .port_rdata(port_rdata), .port_direction_control(port_direction_control));

// ### testbench/exc_cpu_model.sv
// cpu sequencer model marking instruction and handling boundaries
`timescale 1ns/1ns
module exc_cpu_model (
   // clock and reset
   input wire logic       clock,
   input wire logic       rst,
   // sequencer link
   input wire logic       exc_take,
   input wire logic [3:0] gap,
   output logic           instr_boundary
);
   logic [3:0] cnt_r;
   // a take starts handling, so the next boundary is a full gap away
   always_ff @(negedge clock or posedge rst) begin
      if (rst) begin
         cnt_r <= 4'h0;
         instr_boundary <= 1'b0;
      end else begin
         cnt_r <= (exc_take || cnt_r == 4'h0) ? gap : cnt_r - 4'h1;
         instr_boundary <= (cnt_r == 4'h0) && !exc_take;
      end
   end
endmodule : exc_cpu_model

// ### testbench/exception_vector_priority_bench.sv
// self-checking bench for exception arbitration and port registers
`timescale 1ns/1ns
module exception_vector_priority_bench;
   logic        clock, rst, pin_n, wdog, nmi_n, brk, ccr_wr, ccr_wd, bnd, psel, pwr, prd, pbclr, imask, creset, take;
   logic [2:0]  pbit;
   logic [7:0]  pwd, ppin, prdata, pdata, pdir;
   logic [12:0] ext_n, eclr, eflag;
   logic [36:0] ireq;
   logic [5:0]  vnum;
   logic [23:0] vaddr;
   logic [3:0]  gap;
   logic [31:0] seed;
   int          mismatches, samples_checked, nb;

   exception_vector_priority #(.WDT_HOLD(2)) i_dut (
      .clock(clock), .rst(rst), .external_reset_pin_n(pin_n), .watchdog_overflow(wdog), .nmi_pin_n(nmi_n),
      .pin_request_zero_n(ext_n[0]), .pin_request_one_n(ext_n[1]), .event_counter_request_n(ext_n[2]),
      .pin_request_three_n(ext_n[3]), .pin_request_four_n(ext_n[4]), .wakeup_request_n(ext_n[12:5]),
      .ext_flag_clear(eclr), .ext_flag(eflag), .address_break_req(brk), .internal_req(ireq),
      .instr_boundary(bnd), .ccr_i_write(ccr_wr), .ccr_i_wdata(ccr_wd), .ccr_i_mask(imask),
      .chip_reset(creset), .exc_take(take), .exc_vector_number(vnum), .exc_vector_address(vaddr),
      .port_sel(psel), .port_wr(pwr), .port_rd(prd), .port_bit_clear_instruction(pbclr), .port_bit(pbit), .port_wdata(pwd),
      .port_rdata(prdata), .port_pin_in(ppin), .port_output_data(pdata), .port_direction_control(pdir));
   exc_cpu_model i_cpu (.clock(clock), .rst(rst), .exc_take(take), .gap(gap), .instr_boundary(bnd));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
      end
   endtask : chk_val

   task automatic chk_vec(input logic got, input int n);
      samples_checked++;
      if (got !== 1'b1 || vnum !== 6'(n) || vaddr !== 24'(n * 4)) begin
         mismatches++;
         $display("[ERR] %0t take %b vector %0d want %0d", $time, got, vnum, n);
      end
   endtask : chk_vec

   // waits for a take, counting boundaries seen on the way
   task automatic wait_take(input int lim, output logic got);
      got = 1'b0;
      nb = 0;
      for (int i = 0; i < lim && !got; i++) begin
         @(posedge clock);
         #1;
         if (bnd === 1'b1) nb++;
         got = (take === 1'b1);
      end
   endtask : wait_take

   task automatic ccr_write(input logic v);
      @(negedge clock);
      ccr_wr <= 1'b1;
      ccr_wd <= v;
      @(negedge clock);
      ccr_wr <= 1'b0;
   endtask : ccr_write

   task automatic port_op(input logic s, w, r, c, input logic [2:0] b, input logic [7:0] d);
      @(negedge clock);
      {psel, pwr, prd, pbclr, pbit, pwd} <= {s, w, r, c, b, d};
      @(negedge clock);
      {pwr, prd, pbclr} <= 3'b000;
   endtask : port_op

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial begin
      #1000000;
      mismatches++;
      test_done();
   end

   initial begin : main
      logic got;
      logic [7:0] e;
      int k, j;
      {wdog, brk, ccr_wr, ccr_wd, psel, pwr, prd, pbclr, pbit, pwd, ppin, eclr, ireq} = '0;
      {rst, pin_n, nmi_n, ext_n, gap, seed} = {3'b111, 13'h1fff, 4'h3, 32'hd96b31ce};
      repeat (16) @(negedge clock);
      rst = 1'b0;
      wait_take(20, got);
      chk_vec(got, 0);
      chk_val(imask, 24'h1, "mask after reset");
      @(negedge clock) nmi_n <= 1'b0;
      wait_take(40, got);
      chk_val(24'(nb), 24'h2, "boundaries before first take");
      chk_vec(got, 3);
      $display("test reset_first done");
      for (int it = 0; it < 6; it++) begin
         seed = lfsr(seed);
         k = (it == 0) ? 12 : seed % 13;
         j = (it == 0) ? 36 : (seed >> 8) % 37;
         gap = (it == 5) ? 4'hf : seed[19:16] & 4'h7;
         @(negedge clock);
         {ext_n[k], ireq[j], nmi_n} <= 3'b011;
         wait_take(40, got);
         chk_val(got, 24'h0, "take while masked");
         chk_val(eflag[k], 24'h1, "flag kept");
         ccr_write(1'b0);
         wait_take(40, got);
         chk_vec(got, 6 + k);
         @(negedge clock);
         {eclr[k], ext_n[k]} <= 2'b11;
         @(negedge clock);
         eclr <= '0;
         chk_val(eflag[k], 24'h0, "flag cleared");
         ccr_write(1'b0);
         wait_take(40, got);
         chk_vec(got, 19 + j);
         @(negedge clock) ireq <= '0;
      end
      $display("test mask_priority done");
      {brk, nmi_n} <= 2'b10;
      wait_take(40, got);
      chk_vec(got, 3);
      wait_take(40, got);
      chk_vec(got, 5);
      @(negedge clock) {brk, nmi_n} <= 2'b01;
      $display("test break_nmi done");
      @(negedge clock) wdog <= 1'b1;
      @(negedge clock) wdog <= 1'b0;
      chk_val(creset, 24'h1, "watchdog reset");
      wait_take(30, got);
      chk_vec(got, 0);
      @(negedge clock) pin_n <= 1'b0;
      wait_take(20, got);
      chk_val({got, creset}, 24'h1, "pin held");
      @(negedge clock) pin_n <= 1'b1;
      wait_take(20, got);
      chk_vec(got, 0);
      $display("test resets done");
      port_op(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h3f);
      port_op(1'b0, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
      chk_val(prdata, 24'hff, "direction read");
      port_op(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 8'h00);
      chk_val(pdir, 24'hfe, "direction clear");
      for (int it = 0; it < 4; it++) begin
         seed = lfsr(seed);
         ppin <= seed[23:16];
         port_op(1'b0, 1'b1, 1'b0, 1'b0, 3'h0, seed[7:0]);
         port_op(1'b1, 1'b1, 1'b0, 1'b0, 3'h0, seed[15:8]);
         port_op(1'b1, 1'b0, 1'b0, 1'b1, seed[26:24], 8'h00);
         e = ((seed[15:8] & seed[7:0]) | (seed[23:16] & ~seed[7:0])) & ~(8'h01 << seed[26:24]);
         chk_val(pdata, e, "data clear");
         port_op(1'b1, 1'b0, 1'b1, 1'b0, 3'h0, 8'h00);
         chk_val(prdata, (e & seed[7:0]) | (seed[23:16] & ~seed[7:0]), "data read");
         port_op(1'b0, 1'b0, 1'b0, 1'b1, seed[26:24], 8'h00);
         e = ~(8'h01 << seed[26:24]);
         chk_val(pdir, e, "direction clear");
      end
      $display("test ports done");
      test_done();
   end
endmodule : exception_vector_priority_bench
